// ===== hdl/dipm_pkg.sv
// Package with constants and types for the digital input protection mapper.
// Notes on behaviour
// - 3206 shows text, forces status page three
// - 3301 active commands fuel pump start
// - 3302 active commands fuel pump stop
// - 4001 active raises warning with text
// - 4002 active raises unload, larger variant only
// - 4003 active issues deactivation unconditionally
// - 4004 active raises interlock unconditionally
// - 4011 acts as block after oil delay
// - 4012 raises unload after oil delay, larger variant only
// - 4013 deactivates after delay; engine override gives warning
// - 4014 interlock after delay; overrides give warning
// - 4021 warning while input and breaker command
// - 4022 unload while input and breaker command, larger variant only
// - 4023 deactivation while input and breaker command
// - 4024 interlock while input and breaker command
// - 4031 warning while input and fuel solenoid
package dipm_pkg;

  localparam int unsigned NUM_INPUTS = 8;

  localparam logic [15:0] FN_NONE         = 16'h0000;
  localparam logic [15:0] FN_STATUS_PAGE3 = 16'd3206;
  localparam logic [15:0] FN_PUMP_START   = 16'd3301;
  localparam logic [15:0] FN_PUMP_STOP    = 16'd3302;
  localparam logic [15:0] FN_WARN         = 16'd4001;
  localparam logic [15:0] FN_UNLOAD       = 16'd4002;
  localparam logic [15:0] FN_DEACT        = 16'd4003;
  localparam logic [15:0] FN_INTERLOCK    = 16'd4004;
  localparam logic [15:0] FN_OIL_BLOCK    = 16'd4011;
  localparam logic [15:0] FN_OIL_UNLOAD   = 16'd4012;
  localparam logic [15:0] FN_OIL_DEACT    = 16'd4013;
  localparam logic [15:0] FN_OIL_ILOCK    = 16'd4014;
  localparam logic [15:0] FN_GB_WARN      = 16'd4021;
  localparam logic [15:0] FN_GB_UNLOAD    = 16'd4022;
  localparam logic [15:0] FN_GB_DEACT     = 16'd4023;
  localparam logic [15:0] FN_GB_ILOCK     = 16'd4024;
  localparam logic [15:0] FN_FS_WARN      = 16'd4031;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_OIL_DELAY = 8'h04;
  localparam logic [7:0] REG_INPUTS    = 8'h08;
  localparam logic [7:0] REG_ACTIONS   = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h14;
  localparam logic [7:0] REG_FUNC_BASE = 8'h20;

  // Control register bits.
  localparam int unsigned CTRL_LARGE    = 0;
  localparam int unsigned CTRL_OVR_ENG  = 1;
  localparam int unsigned CTRL_OVR_FULL = 2;

  // Action vector bits, shared by the action and interrupt registers.
  localparam int unsigned ACT_WARN   = 0;
  localparam int unsigned ACT_UNLOAD = 1;
  localparam int unsigned ACT_DEACT  = 2;
  localparam int unsigned ACT_ILOCK  = 3;
  localparam int unsigned ACT_PSTART = 4;
  localparam int unsigned ACT_PSTOP  = 5;
  localparam int unsigned ACT_PAGE3  = 6;
  localparam int unsigned ACT_W      = 7;

  localparam logic [31:0] OIL_DELAY_RESET = 32'h0000_0000;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    DIPM_OIL_IDLE = 2'b01,
    DIPM_OIL_RUN  = 2'b10
  } dipm_oil_t;

endpackage : dipm_pkg

// ===== hdl/dipm_top.sv
// Maps debounced digital inputs through function codes to protection actions.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module dipm_top
  import dipm_pkg::*;
#(
  parameter int unsigned N = NUM_INPUTS
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [N-1:0]  din,
  input  wire logic          engine_running,
  input  wire logic          generator_breaker,
  input  wire logic          fuel_solenoid_output,
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               warning,
  output logic               unload,
  output logic               deactivation,
  output logic               interlock,
  output logic               pump_start,
  output logic               pump_stop,
  output logic               status_page3,
  output logic [N-1:0]       msg_active,
  output logic               irq
);

  // All state is one packed struct, so reset and the register stage are each written once.
  typedef struct packed {
    logic [N-1:0]         s1, s2, s3, din;
    logic [2:0]           eng_s;
    logic                 eng_prev;
    logic [2:0]           ctrl;
    logic [31:0]          oil_delay;
    logic [31:0]          oil_cnt;
    dipm_oil_t            oil_st;
    logic                 oil_done;
    logic [N-1:0][15:0]   func;
    logic [ACT_W-1:0]     act;
    logic [N-1:0]         msg;
    logic [ACT_W-1:0]     stat;
    logic [ACT_W-1:0]     mask;
    logic                 irq;
    logic                 aw_got, w_got;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } dipm_state_t;

  dipm_state_t q, d;

  function automatic logic is_func_addr(input logic [7:0] a);
    return (a >= REG_FUNC_BASE) && (a < REG_FUNC_BASE + 8'(4 * N)) && (a[1:0] == 2'b00);
  endfunction : is_func_addr

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Function-code slots sit one word apart above the slot base.
  function automatic logic [7:0] func_index(input logic [7:0] a);
    return (a - REG_FUNC_BASE) >> 2;
  endfunction : func_index

  logic [ACT_W-1:0] act_now;
  logic [N-1:0]     msg_now;
  logic             ovr_eng;
  logic             ovr_any;
  logic [7:0]       ra;
  logic [31:0]      rd;
  logic [31:0]      wv;
  logic             rd_ok;
  logic             wr_ok;
  logic             do_wr;
  logic [31:0]      ctrl_m;
  logic [31:0]      mask_m;
  logic [31:0]      func_m;
  logic [7:0]       widx;
  logic [7:0]       ridx;

  always_comb begin
    d = q;
    // Field contacts are asynchronous: three stages, a change counts once stages two and three agree.
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < N; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.din[i] = q.s3[i];
      end
    end
    // Engine running is a field signal too and takes the same three-stage path.
    d.eng_s = {q.eng_s[1:0], engine_running};
    if (q.eng_s[1] == q.eng_s[2]) begin
      d.eng_prev = q.eng_s[2];
    end

    // The oil delay counts from each new running detection and is dropped when the engine stops.
    case (q.oil_st)
      DIPM_OIL_IDLE: begin
        d.oil_done = 1'b0;
        if (d.eng_prev && !q.eng_prev) begin
          d.oil_cnt = 32'h0000_0000;
          d.oil_st  = DIPM_OIL_RUN;
        end
      end
      // The counter holds at the delay, so done stays high for as long as the engine runs.
      DIPM_OIL_RUN: begin
        if (!d.eng_prev) begin
          d.oil_st   = DIPM_OIL_IDLE;
          d.oil_done = 1'b0;
        end else if (q.oil_cnt >= q.oil_delay) begin
          d.oil_done = 1'b1;
        end else begin
          d.oil_cnt = q.oil_cnt + 32'h0000_0001;
        end
      end
      default: begin
        d.oil_st   = DIPM_OIL_IDLE;
        d.oil_done = 1'b0;
      end
    endcase

    // Breaker and solenoid commands come from logic on this clock, so they are used without a synchroniser.
    // Only the engine override downgrades 4013; either override downgrades 4014.
    // Several inputs may drive the same action, so each one only adds to the shared vector.
    ovr_eng = q.ctrl[CTRL_OVR_ENG];
    ovr_any = q.ctrl[CTRL_OVR_ENG] | q.ctrl[CTRL_OVR_FULL];
    act_now = '0;
    msg_now = '0;
    for (int i = 0; i < N; i++) begin
      if (q.din[i]) begin
        case (q.func[i])
          FN_STATUS_PAGE3: begin
            act_now[ACT_PAGE3] = 1'b1;
            msg_now[i] = 1'b1;
          end
          FN_PUMP_START: act_now[ACT_PSTART] = 1'b1;
          FN_PUMP_STOP:  act_now[ACT_PSTOP] = 1'b1;
          FN_WARN: begin
            act_now[ACT_WARN] = 1'b1;
            msg_now[i] = 1'b1;
          end
          FN_UNLOAD: begin
            if (q.ctrl[CTRL_LARGE]) begin
              act_now[ACT_UNLOAD] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_DEACT: begin
            act_now[ACT_DEACT] = 1'b1;
            msg_now[i] = 1'b1;
          end
          FN_INTERLOCK: begin
            act_now[ACT_ILOCK] = 1'b1;
            msg_now[i] = 1'b1;
          end
          FN_OIL_BLOCK: begin
            // Named a warning, but behaves as a block once the delay is over.
            if (q.oil_done) begin
              act_now[ACT_ILOCK] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_OIL_UNLOAD: begin
            if (q.oil_done && q.ctrl[CTRL_LARGE]) begin
              act_now[ACT_UNLOAD] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_OIL_DEACT: begin
            if (q.oil_done) begin
              msg_now[i] = 1'b1;
              if (ovr_eng) begin
                act_now[ACT_WARN] = 1'b1;
              end else begin
                act_now[ACT_DEACT] = 1'b1;
              end
            end
          end
          FN_OIL_ILOCK: begin
            if (q.oil_done) begin
              msg_now[i] = 1'b1;
              if (ovr_any) begin
                act_now[ACT_WARN] = 1'b1;
              end else begin
                act_now[ACT_ILOCK] = 1'b1;
              end
            end
          end
          FN_GB_WARN: begin
            if (generator_breaker) begin
              act_now[ACT_WARN] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_GB_UNLOAD: begin
            if (generator_breaker && q.ctrl[CTRL_LARGE]) begin
              act_now[ACT_UNLOAD] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_GB_DEACT: begin
            if (generator_breaker) begin
              act_now[ACT_DEACT] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_GB_ILOCK: begin
            if (generator_breaker) begin
              act_now[ACT_ILOCK] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          FN_FS_WARN: begin
            if (fuel_solenoid_output) begin
              act_now[ACT_WARN] = 1'b1;
              msg_now[i] = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Actions and texts are registered, so outputs stand one cycle after their cause.
    d.act = act_now;
    d.msg = msg_now;

    // AXI4-Lite write: address and data are taken in either order, response follows both.
    wr_ok = 1'b0;
    do_wr = 1'b0;
    if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      do_wr    = 1'b1;
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Events set sticky status; a one written clears it, but a new event in the same cycle wins.
    wv     = merge(32'h0000_0000, q.w_data, q.w_strb);
    ctrl_m = merge({29'h0, q.ctrl}, q.w_data, q.w_strb);
    mask_m = merge({25'h0, q.mask}, q.w_data, q.w_strb);
    widx   = func_index(q.aw_addr);
    func_m = 32'h0000_0000;
    if (do_wr) begin
      wr_ok = 1'b1;
      case (q.aw_addr)
        REG_CTRL:      d.ctrl = ctrl_m[2:0];
        REG_OIL_DELAY: d.oil_delay = merge(q.oil_delay, q.w_data, q.w_strb);
        REG_IRQ_STAT:  d.stat = q.stat & ~wv[ACT_W-1:0];
        REG_IRQ_MASK:  d.mask = mask_m[ACT_W-1:0];
        // Status words are read-only; a write there is answered OKAY and has no effect.
        REG_INPUTS, REG_ACTIONS: begin
        end
        default: begin
          if (is_func_addr(q.aw_addr)) begin
            func_m       = merge({16'h0, q.func[widx]}, q.w_data, q.w_strb);
            d.func[widx] = func_m[15:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
      endcase
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.stat = d.stat | (act_now & ~q.act);
    // Next-state status and mask feed the interrupt, so it moves in the same cycle as they do.
    d.irq  = |(d.stat & d.mask);

    // AXI4-Lite read: one-cycle answer after the address is taken.
    // Only eight address bits are decoded, so the map repeats every 256 bytes.
    ra    = s_axi_araddr[7:0];
    ridx  = func_index(ra);
    rd    = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ra)
      REG_CTRL:      rd = {29'h0, q.ctrl};
      REG_OIL_DELAY: rd = q.oil_delay;
      REG_INPUTS:    rd = 32'(q.din);
      REG_ACTIONS:   rd = {q.oil_done, 24'h0, q.act};
      REG_IRQ_STAT:  rd = {25'h0, q.stat};
      REG_IRQ_MASK:  rd = {25'h0, q.mask};
      default: begin
        if (is_func_addr(ra)) begin
          rd = {16'h0, q.func[ridx]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase

    // The word is captured when the address is taken, so a later register change cannot disturb it.
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // Reset values are written out so that a changed package default reaches the flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q           <= '0;
      q.ctrl      <= CTRL_RESET;
      q.oil_delay <= OIL_DELAY_RESET;
      q.oil_st    <= DIPM_OIL_IDLE;
    end else begin
      q <= d;
    end
  end

  // Every output is taken from state fields only, so no input reaches a pin combinationally.
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign warning       = q.act[ACT_WARN];
  assign unload        = q.act[ACT_UNLOAD];
  assign deactivation  = q.act[ACT_DEACT];
  assign interlock     = q.act[ACT_ILOCK];
  assign pump_start    = q.act[ACT_PSTART];
  assign pump_stop     = q.act[ACT_PSTOP];
  assign status_page3  = q.act[ACT_PAGE3];
  assign msg_active    = q.msg;
  assign irq           = q.irq;

endmodule : dipm_top

// ===== test/dipm_contacts.sv
// Field contact model wired to the configurable digital inputs.
`timescale 1ns/1ns
module dipm_contacts #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] close_cmd,
  output wire logic [N-1:0] din
);
  // Contacts are not tied to the controller clock, so each change lands mid-cycle.
  assign #3 din = close_cmd;
endmodule : dipm_contacts

// ===== test/dipm_top_assertions.sv
// Port-level checker for the digital input protection mapper.
`timescale 1ns/1ns
module dipm_checker
  import dipm_pkg::*;
#(
  parameter int unsigned N = NUM_INPUTS
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic         warning,
  input wire logic         unload,
  input wire logic         deactivation,
  input wire logic         interlock,
  input wire logic         status_page3,
  input wire logic [N-1:0] msg_active,
  input wire logic         irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before its handshake");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before its handshake");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while a response is pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data is pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
    ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_page_text: assert property ($rose(status_page3) |-> (|$past(msg_active)) or ##[0:2] (|msg_active))
    else $error("status page raised without a text");
  a_alarm_text: assert property ($rose(warning | unload | deactivation | interlock) |->
    (|$past(msg_active)) or ##[0:2] (|msg_active))
    else $error("protection raised without a text");

  cp_write: cover property (s_axi_bvalid && s_axi_bready);
  cp_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cp_ilock: cover property ($rose(interlock));
  cp_irq: cover property ($rose(irq));
endmodule : dipm_checker

bind dipm_top dipm_checker #(.N(N)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .warning(warning), .unload(unload),
  .deactivation(deactivation), .interlock(interlock), .status_page3(status_page3),
  .msg_active(msg_active), .irq(irq));

// ===== test/dipm_top_test.sv
// Self-checking bench for the digital input protection mapper.
`timescale 1ns/1ns
module dipm_top_test;
  import dipm_pkg::*;
  logic        aclk, aresetn, engine_running, generator_breaker, fuel_solenoid_output;
  logic [7:0]  contact_cmd;
  wire  [7:0]  din;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        warning, unload, deactivation, interlock, pump_start, pump_stop, status_page3, irq;
  logic [7:0]  msg_active;
  int          num_errors, cmp_count, cycles;
  wire  [6:0]  act = {status_page3, pump_stop, pump_start, interlock, deactivation, unload, warning};

  dipm_contacts #(.N(8)) u_contacts (.close_cmd(contact_cmd), .din(din));
  dipm_top #(.N(8)) uut (
    .aclk(aclk), .aresetn(aresetn), .din(din), .engine_running(engine_running),
    .generator_breaker(generator_breaker), .fuel_solenoid_output(fuel_solenoid_output),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .warning(warning), .unload(unload), .deactivation(deactivation),
    .interlock(interlock), .pump_start(pump_start), .pump_stop(pump_stop), .status_page3(status_page3),
    .msg_active(msg_active), .irq(irq));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= 32'(a);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= 32'(a);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Configures input 0, sets the gating commands and compares the action outputs.
  task automatic probe(input logic [15:0] code, input logic [2:0] ctrl, input logic gb, input logic fs,
                       input logic [6:0] exp);
    wr(REG_CTRL, 32'(ctrl));
    wr(REG_FUNC_BASE, 32'(code));
    generator_breaker <= gb;
    fuel_solenoid_output <= fs;
    tick(8);
    check(32'(act), 32'(exp));
    if (exp != 7'h00 && exp[5:4] == 2'b00) check(32'(msg_active[0]), 32'h0000_0001);
  endtask : probe

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(REG_CTRL, d, r);
    check(d, 32'h0000_0000);
    rd(REG_FUNC_BASE, d, r);
    check(d, 32'(FN_NONE));
    rd(8'h18, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    wr(8'h18, 32'h0000_0001);
    check(32'(bresp), 32'(RESP_SLVERR));
    wr(REG_OIL_DELAY, 32'h0000_000A);
    check(32'(bresp), 32'(RESP_OKAY));
    rd(REG_OIL_DELAY, d, r);
    check(d, 32'h0000_000A);
  endtask : t_regs

  task automatic t_direct;
    contact_cmd <= 8'h01;
    probe(FN_STATUS_PAGE3, 3'h0, 1'b0, 1'b0, 7'h40);
    probe(FN_PUMP_START, 3'h0, 1'b0, 1'b0, 7'h10);
    probe(FN_PUMP_STOP, 3'h0, 1'b0, 1'b0, 7'h20);
    probe(FN_WARN, 3'h0, 1'b0, 1'b0, 7'h01);
    probe(FN_UNLOAD, 3'h0, 1'b0, 1'b0, 7'h00);
    probe(FN_UNLOAD, 3'h1, 1'b0, 1'b0, 7'h02);
    probe(FN_DEACT, 3'h0, 1'b0, 1'b0, 7'h04);
    probe(FN_INTERLOCK, 3'h0, 1'b0, 1'b0, 7'h08);
    contact_cmd <= 8'h00;
    tick(10);
    check(32'(act), 32'h0000_0000);
  endtask : t_direct

  task automatic t_gated;
    contact_cmd <= 8'h01;
    probe(FN_GB_WARN, 3'h1, 1'b0, 1'b1, 7'h00);
    probe(FN_GB_WARN, 3'h1, 1'b1, 1'b0, 7'h01);
    probe(FN_GB_UNLOAD, 3'h1, 1'b0, 1'b0, 7'h00);
    probe(FN_GB_UNLOAD, 3'h0, 1'b1, 1'b0, 7'h00);
    probe(FN_GB_UNLOAD, 3'h1, 1'b1, 1'b0, 7'h02);
    probe(FN_GB_DEACT, 3'h1, 1'b0, 1'b1, 7'h00);
    probe(FN_GB_DEACT, 3'h1, 1'b1, 1'b0, 7'h04);
    probe(FN_GB_ILOCK, 3'h1, 1'b0, 1'b1, 7'h00);
    probe(FN_GB_ILOCK, 3'h1, 1'b1, 1'b0, 7'h08);
    probe(FN_FS_WARN, 3'h1, 1'b1, 1'b0, 7'h00);
    probe(FN_FS_WARN, 3'h1, 1'b0, 1'b1, 7'h01);
  endtask : t_gated

  task automatic t_oil;
    logic [31:0] d;
    logic [1:0]  r;
    contact_cmd <= 8'h01;
    wr(REG_OIL_DELAY, 32'h0000_000A);
    probe(FN_OIL_BLOCK, 3'h0, 1'b0, 1'b0, 7'h00);
    // The second pass shows the delay restarting at a new running detection.
    repeat (2) begin
      engine_running <= 1'b0;
      tick(10);
      check(32'(act), 32'h0000_0000);
      engine_running <= 1'b1;
      tick(6);
      check(32'(act), 32'h0000_0000);
      tick(30);
      check(32'(act), 32'h0000_0008);
      rd(REG_ACTIONS, d, r);
      check(d, 32'h8000_0008);
    end
    probe(FN_OIL_UNLOAD, 3'h0, 1'b0, 1'b0, 7'h00);
    probe(FN_OIL_UNLOAD, 3'h1, 1'b0, 1'b0, 7'h02);
    probe(FN_OIL_DEACT, 3'h0, 1'b0, 1'b0, 7'h04);
    probe(FN_OIL_DEACT, 3'h2, 1'b0, 1'b0, 7'h01);
    probe(FN_OIL_ILOCK, 3'h0, 1'b0, 1'b0, 7'h08);
    probe(FN_OIL_ILOCK, 3'h2, 1'b0, 1'b0, 7'h01);
    probe(FN_OIL_ILOCK, 3'h4, 1'b0, 1'b0, 7'h01);
    engine_running <= 1'b0;
  endtask : t_oil

  task automatic t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    contact_cmd <= 8'h00;
    probe(FN_WARN, 3'h0, 1'b0, 1'b0, 7'h00);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    wr(REG_IRQ_STAT, 32'h0000_007F);
    contact_cmd <= 8'h01;
    tick(10);
    rd(REG_IRQ_STAT, d, r);
    check(32'(d[6:0]), 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    tick(3);
    check(32'(irq), 32'h0000_0001);
    wr(REG_IRQ_STAT, 32'h0000_0001);
    tick(3);
    check(32'(irq), 32'h0000_0000);
  endtask : t_irq

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Every scenario together needs under a thousand cycles; the ceiling leaves wide margin.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    aresetn = 1'b0;
    engine_running = 1'b0;
    generator_breaker = 1'b0;
    fuel_solenoid_output = 1'b0;
    contact_cmd = 8'h00;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    tick(8);
    aresetn <= 1'b1;
    t_regs();
    t_direct();
    t_gated();
    t_oil();
    t_irq();
    give_verdict();
  end
endmodule : dipm_top_test
